// File: rtl/dam_pkg.sv
// Package of the drive alarm manager: register addresses, code tables,
// flash timing and the structs that carry bus requests and link faults.
// Assumes a single 40 MHz core clock shared by every user of the package.
package dam_pkg;

   // ----------------------------------------------------------------------
   // Clock and flash timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_HZ      = 40_000_000;
   localparam int unsigned TICK_MS     = 50;
   localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned PULSE_MS    = 200;
   localparam int unsigned PAUSE_MS    = 1000;
   localparam int unsigned COMM_PER_MS = 1600;
   localparam logic [4:0]  PULSE_TK      = 5'(PULSE_MS / TICK_MS);
   localparam logic [4:0]  PULSE_PAIR_TK = 5'(2 * PULSE_MS / TICK_MS);
   localparam logic [4:0]  PAUSE_TK      = 5'(PAUSE_MS / TICK_MS);
   localparam logic [5:0]  COMM_PER_TK   = 6'(COMM_PER_MS / TICK_MS);

   // ----------------------------------------------------------------------
   // Register addresses and field values
   // ----------------------------------------------------------------------
   localparam logic [15:0] OBJ_HIST     = 16'h3FFE;
   localparam logic [15:0] OBJ_ERRREG   = 16'h1001;
   localparam logic [15:0] OBJ_ERRCODE  = 16'h603F;
   localparam logic [15:0] OBJ_ALMCLR   = 16'h2057;
   localparam logic [15:0] OBJ_HISTCLR  = 16'h2093;
   localparam logic [15:0] OBJ_CTRLWORD = 16'h6040;
   localparam logic [15:0] OBJ_ALMSTATE = 16'h2F00;
   localparam logic [15:0] SC_CTRL      = 16'h0120;
   localparam logic [15:0] SC_STATUS    = 16'h0134;
   localparam logic [15:0] CLR_VAL      = 16'h0001;
   localparam int unsigned SC_ACK_BIT   = 4;
   localparam int unsigned CW_RESET_BIT = 7;
   localparam logic [7:0]  ERR_COMM     = 8'h10;

   // ----------------------------------------------------------------------
   // Drive fault table, index = fault input bit
   // ----------------------------------------------------------------------
   localparam int unsigned NDRV = 8;
   localparam logic [2:0]  DF_OC = 3'h0;
   localparam logic [15:0] DRV_HIST [NDRV] =
      '{16'h00E0, 16'h00A0, 16'h00A1, 16'h00C0, 16'h01A0, 16'h0240, 16'h01A1, 16'h05F0};
   localparam logic [7:0]  DRV_ERR [NDRV] =
      '{8'h02, 8'h04, 8'h04, 8'h04, 8'h20, 8'h80, 8'h20, 8'h80};
   localparam logic [15:0] DRV_PROF [NDRV] =
      '{16'h2211, 16'h3150, 16'h3151, 16'h3211, 16'h8402, 16'h5530, 16'h8403, 16'h7122};
   localparam logic [3:0]  DRV_FLASH [NDRV] =
      '{4'h1, 4'hC, 4'hC, 4'h2, 4'h5, 4'h8, 4'h3, 4'h7};
   localparam logic [7:0]  DRV_CLEARABLE = 8'h78;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      PAT_SINGLE  = 4'b0001,
      PAT_DOUBLE  = 4'b0010,
      PAT_BLINK   = 4'b0100,
      PAT_FLICKER = 4'b1000
   } dam_pat_t;

   typedef enum logic [1:0] {
      DS_SWDIS = 2'b01,
      DS_FAULT = 2'b10
   } dam_ds_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dam_bus_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] code;
   } dam_comm_fault_t;

endpackage

// File: rtl/dam_core.sv
// Drive alarm manager: latches drive and link faults, keeps the alarm code
// objects, drives the two red indicator elements and the motor halt.
// Assumes fault pins are asynchronous and the link fault strobe comes from
// logic on core_clk; the register port master never waits.
//
// Contract
// RQ1: Any drive fault halts the motor and flashes its pattern on the power alarm red.
// RQ2: Over current 0x0E0/0x02/0x2211, 1 flash, sticky; over voltage 0x0C0/0x04/0x3211, 2, clearable.
// RQ3: Over velocity 0x1A0/0x20/0x8402, 5 flashes; command limit 0x1A1/0x20/0x8403, 3; clearable.
// RQ4: Memory error 0x240/0x80/0x5530, 8, clearable; motor cable 0x5F0/0x80/0x7122, 7, sticky.
// RQ5: Phase A amplifier failure 0x0A0/0x04/0x3150, 12 flashes, sticky.
// RQ6: Phase B amplifier failure 0x0A1/0x04/0x3151, 12 flashes, sticky.
// RQ7: History alarm code is readable at object 3FFEh.
// RQ8: Present alarm error-register code is readable at object 1001h.
// RQ9: Present alarm profile error code is readable at object 603Fh.
// RQ10: Writing 1 to 2057h clears clearable alarms whose cause has gone.
// RQ11: Writing 1 to 2093h erases the history alarm code.
// RQ12: Control word bit 7 rising moves drive state from Fault to Switch on disabled.
// RQ13: Sticky faults ignore software clears and stay until reset.
// RQ14: The newest alarm overwrites every alarm code object; link faults with no history code leave 3FFEh as it was.
// RQ15: Every link fault sets error register 0x10 and flashes the link fault red.
// RQ16: Sync manager watchdog timeout reports 0x821B, stores 0x001B, double flash.
// RQ17: Clock sync faults 0x871A, 0x8732-0x8734 store their history, single flash.
// RQ18: State transition faults 0xA001-0xA005 store history, blinking pattern.
// RQ19: Boot faults flicker, other setup faults blink; neither stored in history.
// RQ20: Link faults are acknowledged by writing bit 4 of controller register 0x120.
// RQ21: After acknowledge, status code 0x134 reads zero and the link alarm drops.
// RQ22: Flash count patterns are equal pulse bursts then a longer dark pause.
//
// Local design decisions: the strobed register port and the register offsets.

`timescale 1ns/10ps

module dam_core
   import dam_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input  wire logic            core_clk,
   input  wire logic            nrst,
   input  wire logic            ce,
   input  wire dam_bus_req_t    bus_req,
   output logic [15:0]          rdata,
   input  wire logic [NDRV-1:0] drv_fault_pin,
   input  wire dam_comm_fault_t comm_fault,
   output logic                 motor_halt,
   output logic                 power_alarm_red,
   output logic                 link_fault_red,
   output logic                 drive_in_fault
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // Index of the lowest set bit; ties between new faults resolve low first.
   function automatic logic [2:0] first_set(input logic [NDRV-1:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = NDRV - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // History code of a link fault; bit 16 says whether it is stored at all.
   function automatic logic [16:0] comm_hist(input logic [15:0] code);
      case (code)
         16'h821B: comm_hist = {1'b1, 16'h001B};
         16'h821C: comm_hist = {1'b1, 16'h001C};
         16'h871A: comm_hist = {1'b1, 16'h001A};
         16'h8732: comm_hist = {1'b1, 16'h0032};
         16'h8733: comm_hist = {1'b1, 16'h0033};
         16'h8734: comm_hist = {1'b1, 16'h0034};
         16'hA001: comm_hist = {1'b1, 16'h0011};
         16'hA002: comm_hist = {1'b1, 16'h0012};
         16'hA003: comm_hist = {1'b1, 16'h0021};
         16'hA004: comm_hist = {1'b1, 16'h0022};
         16'hA005: comm_hist = {1'b1, 16'h0023};
         default:  comm_hist = {1'b0, 16'h0000};
      endcase
   endfunction

   // Indicator pattern of a link fault.
   function automatic dam_pat_t comm_pat(input logic [15:0] code);
      case (code)
         16'h8213, 16'h8215, 16'h8216, 16'h8217: comm_pat = PAT_FLICKER;
         16'h821B:                               comm_pat = PAT_DOUBLE;
         16'h871A, 16'h872D, 16'h8732,
         16'h8733, 16'h8734:                     comm_pat = PAT_SINGLE;
         default:                                comm_pat = PAT_BLINK;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Fault pin synchroniser
   // ----------------------------------------------------------------------
   logic [NDRV-1:0] cause_meta;
   logic [NDRV-1:0] cause;

   // Two flops per pin; only the second is read by the logic.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cause_meta <= '0;
         cause      <= '0;
      end else if (ce) begin
         cause_meta <= drv_fault_pin;
         cause      <= cause_meta;
      end
   end

   // ----------------------------------------------------------------------
   // Register write decode
   // ----------------------------------------------------------------------
   logic        alm_clr_wr;
   logic        hist_clr_wr;
   logic        cw_wr;
   logic        sc_ack_wr;
   logic [15:0] ctrl_word;
   logic        cw_rise;

   // Clear objects act only on the value one; other values are ignored.
   assign alm_clr_wr  = bus_req.wr && bus_req.addr == OBJ_ALMCLR && bus_req.wdata == CLR_VAL;
   assign hist_clr_wr = bus_req.wr && bus_req.addr == OBJ_HISTCLR && bus_req.wdata == CLR_VAL;
   assign cw_wr       = bus_req.wr && bus_req.addr == OBJ_CTRLWORD;
   assign sc_ack_wr   = bus_req.wr && bus_req.addr == SC_CTRL && bus_req.wdata[SC_ACK_BIT]; // RQ20
   assign cw_rise     = cw_wr && bus_req.wdata[CW_RESET_BIT] && !ctrl_word[CW_RESET_BIT];

   // Control word image, kept so a rising bit 7 can be told from a held one.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ctrl_word <= 16'h0000;
      end else if (ce && cw_wr) begin
         ctrl_word <= bus_req.wdata;
      end
   end

   // ----------------------------------------------------------------------
   // Drive fault latches
   // ----------------------------------------------------------------------
   logic [NDRV-1:0] drv_latch;
   logic [NDRV-1:0] next_drv_latch;
   logic [NDRV-1:0] drv_new;
   logic [2:0]      pick;
   logic            any_new;

   assign drv_new = cause & ~drv_latch;
   assign pick    = first_set(drv_new);
   assign any_new = |drv_new;

   // A present cause always sets, so a clear never loses a live fault.
   always_comb begin
      next_drv_latch = drv_latch;
      for (int i = 0; i < NDRV; i++) begin
         if (drv_new[i]) begin
            next_drv_latch[i] = 1'b1;
         end else if (alm_clr_wr && DRV_CLEARABLE[i] && !cause[i]) begin // RQ10 RQ13
            next_drv_latch[i] = 1'b0;
         end
      end
   end

   // Sticky faults only leave through reset, the power cycle of this block.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         drv_latch <= '0;
      end else if (ce) begin
         drv_latch <= next_drv_latch; // RQ13
      end
   end

   // ----------------------------------------------------------------------
   // Link fault latch and slave controller status code
   // ----------------------------------------------------------------------
   logic        comm_alarm;
   logic        next_comm_alarm;
   logic        ack_pend;
   logic [15:0] sc_status;
   dam_pat_t    cpat;
   logic [16:0] chist;

   assign chist = comm_hist(comm_fault.code);

   // A fresh fault in the handling cycle outranks the acknowledge.
   always_comb begin
      next_comm_alarm = comm_alarm;
      if (comm_fault.valid) begin
         next_comm_alarm = 1'b1; // RQ15
      end else if (ack_pend) begin
         next_comm_alarm = 1'b0; // RQ21
      end
   end

   // The acknowledge is handled one cycle after the write.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ack_pend   <= 1'b0;
         comm_alarm <= 1'b0;
         sc_status  <= 16'h0000;
         cpat       <= PAT_BLINK;
      end else if (ce) begin
         ack_pend   <= sc_ack_wr; // RQ20
         comm_alarm <= next_comm_alarm;
         if (comm_fault.valid) begin
            sc_status <= comm_fault.code;
            cpat      <= comm_pat(comm_fault.code); // RQ16 RQ17 RQ18 RQ19
         end else if (ack_pend) begin
            sc_status <= 16'h0000; // RQ21
         end
      end
   end

   // ----------------------------------------------------------------------
   // Alarm code objects
   // ----------------------------------------------------------------------
   logic [15:0] hist;
   logic [7:0]  err_reg;
   logic [15:0] err_code;
   logic [3:0]  drv_flash_n;

   // Newest alarm overwrites the present codes; idle clears them.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         err_reg     <= 8'h00;
         err_code    <= 16'h0000;
         drv_flash_n <= 4'h1;
      end else if (ce) begin
         if (any_new) begin
            err_reg     <= DRV_ERR[pick];   // RQ2 RQ3 RQ4 RQ5 RQ6 RQ8 RQ14
            err_code    <= DRV_PROF[pick];  // RQ9
            drv_flash_n <= DRV_FLASH[pick];
         end else if (comm_fault.valid) begin
            err_reg  <= ERR_COMM;           // RQ15 RQ14
            err_code <= comm_fault.code;
         end else if (!(|next_drv_latch) && !next_comm_alarm) begin
            err_reg  <= 8'h00;
            err_code <= 16'h0000;
         end
      end
   end

   // History keeps the last stored code; a new one wins over an erase.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         hist <= 16'h0000;
      end else if (ce) begin
         if (any_new) begin
            hist <= DRV_HIST[pick]; // RQ7 RQ14
         end else if (comm_fault.valid && chist[16]) begin
            hist <= chist[15:0]; // RQ16 RQ17 RQ18 RQ19
         end else if (hist_clr_wr) begin
            hist <= 16'h0000; // RQ11
         end
      end
   end

   // ----------------------------------------------------------------------
   // Drive state and motor halt
   // ----------------------------------------------------------------------
   dam_ds_t ds;

   // Any new alarm enters Fault; the reset bit edge leaves it.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ds <= DS_SWDIS;
      end else if (ce) begin
         if (any_new || comm_fault.valid) begin
            ds <= DS_FAULT;
         end else begin
            case (ds)
               DS_FAULT: begin
                  if (cw_rise) begin
                     ds <= DS_SWDIS; // RQ12
                  end
               end
               DS_SWDIS: ds <= DS_SWDIS;
               default:  ds <= DS_SWDIS;
            endcase
         end
      end
   end

   // The motor stays halted while any drive fault is latched.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         motor_halt     <= 1'b0;
         drive_in_fault <= 1'b0;
      end else if (ce) begin
         motor_halt     <= |next_drv_latch; // RQ1
         drive_in_fault <= ds == DS_FAULT;
      end
   end

   // ----------------------------------------------------------------------
   // Flash tick prescaler
   // ----------------------------------------------------------------------
   logic [20:0] tick_cnt;
   logic        tick;

   assign tick = tick_cnt == 21'(TICK_CYCLES - 1);

   // One tick per flash time step.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tick_cnt <= 21'h000000;
      end else if (ce) begin
         tick_cnt <= tick ? 21'h000000 : tick_cnt + 21'h000001;
      end
   end

   // ----------------------------------------------------------------------
   // Power alarm flash burst
   // ----------------------------------------------------------------------
   logic [4:0] fl_tk;
   logic [3:0] fl_cnt;
   logic       fl_pause;

   // Burst of equal pulses, then a longer dark pause, while latched.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         fl_tk    <= 5'h00;
         fl_cnt   <= 4'h0;
         fl_pause <= 1'b0;
      end else if (ce) begin
         if (!(|drv_latch)) begin
            fl_tk    <= 5'h00;
            fl_cnt   <= 4'h0;
            fl_pause <= 1'b0;
         end else if (tick) begin
            if (fl_pause) begin
               if (fl_tk == PAUSE_TK - 5'h01) begin // RQ22
                  fl_tk    <= 5'h00;
                  fl_pause <= 1'b0;
               end else begin
                  fl_tk <= fl_tk + 5'h01;
               end
            end else if (fl_tk == PULSE_PAIR_TK - 5'h01) begin
               fl_tk <= 5'h00;
               if (fl_cnt >= drv_flash_n - 4'h1) begin // RQ22
                  fl_cnt   <= 4'h0;
                  fl_pause <= 1'b1;
               end else begin
                  fl_cnt <= fl_cnt + 4'h1;
               end
            end else begin
               fl_tk <= fl_tk + 5'h01;
            end
         end
      end
   end

   // Lit for the first half of each pulse slot outside the pause.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         power_alarm_red <= 1'b0;
      end else if (ce) begin
         power_alarm_red <= (|drv_latch) && !fl_pause && fl_tk < PULSE_TK; // RQ1
      end
   end

   // ----------------------------------------------------------------------
   // Link fault indicator patterns
   // ----------------------------------------------------------------------
   logic [5:0] ph;
   logic       flick;
   logic       pat_on;

   // Free running phase over one pattern period.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ph    <= 6'h00;
         flick <= 1'b0;
      end else if (ce && tick) begin
         ph    <= (ph == COMM_PER_TK - 6'h01) ? 6'h00 : ph + 6'h01;
         flick <= !flick;
      end
   end

   // Pattern shape chosen by the latest link fault.
   always_comb begin
      case (cpat)
         PAT_SINGLE:  pat_on = ph < 6'(PULSE_TK);
         PAT_DOUBLE:  pat_on = ph < 6'(PULSE_TK) ||
                               (ph >= 6'(PULSE_PAIR_TK) && ph < 6'(PULSE_PAIR_TK + PULSE_TK));
         PAT_FLICKER: pat_on = flick;
         PAT_BLINK:   pat_on = ph[2] == 1'b0;
         default:     pat_on = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         link_fault_red <= 1'b0;
      end else if (ce) begin
         link_fault_red <= comm_alarm && pat_on; // RQ15
      end
   end

   // ----------------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------------

   // Read data stand one cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rdata <= 16'h0000;
      end else if (ce) begin
         if (bus_req.rd) begin
            case (bus_req.addr)
               OBJ_HIST:     rdata <= hist;              // RQ7
               OBJ_ERRREG:   rdata <= {8'h00, err_reg};  // RQ8
               OBJ_ERRCODE:  rdata <= err_code;          // RQ9
               OBJ_CTRLWORD: rdata <= ctrl_word;
               SC_STATUS:    rdata <= sc_status;         // RQ21
               OBJ_ALMSTATE: rdata <= {5'h00, ds, comm_alarm, drv_latch};
               default:      rdata <= 16'h0000;
            endcase
         end else begin
            rdata <= 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_ack;
      ce && sc_ack_wr && !comm_fault.valid ##1 ce && !comm_fault.valid;
   endsequence

   sequence s_oc_new;
      ce && drv_new[DF_OC];
   endsequence

   a_motor_halt_follow: assert property (@(posedge core_clk) disable iff (!nrst) // RQ1
      ce && any_new |=> motor_halt && drv_latch != 8'h00)
      else $error("motor not halted on a new drive fault");

   a_overcurrent_codes: assert property (@(posedge core_clk) disable iff (!nrst) // RQ2
      s_oc_new |=> hist == 16'h00E0 && err_reg == 8'h02 && err_code == 16'h2211)
      else $error("over current codes wrong");

   a_sticky_latch: assert property (@(posedge core_clk) disable iff (!nrst) // RQ13
      drv_latch[DF_OC] |=> drv_latch[DF_OC])
      else $error("sticky fault was cleared without reset");

   a_alarm_clear_ok: assert property (@(posedge core_clk) disable iff (!nrst) // RQ10
      ce && alm_clr_wr && drv_latch[3] && !cause[3] |=> !drv_latch[3])
      else $error("clearable alarm not cleared");

   a_hist_erase: assert property (@(posedge core_clk) disable iff (!nrst) // RQ11
      ce && hist_clr_wr && !any_new && !comm_fault.valid |=> hist == 16'h0000)
      else $error("history not erased");

   a_fault_exit: assert property (@(posedge core_clk) disable iff (!nrst) // RQ12
      ce && ds == DS_FAULT && cw_rise && !any_new && !comm_fault.valid |=> ds == DS_SWDIS)
      else $error("fault state not left on control bit edge");

   a_comm_errreg: assert property (@(posedge core_clk) disable iff (!nrst) // RQ15
      ce && comm_fault.valid && !any_new |=> err_reg == 8'h10 && comm_alarm)
      else $error("link fault error register wrong");

   a_watchdog_hist: assert property (@(posedge core_clk) disable iff (!nrst) // RQ16
      ce && comm_fault.valid && comm_fault.code == 16'h821B && !any_new
      |=> hist == 16'h001B && cpat == PAT_DOUBLE)
      else $error("watchdog fault not recorded");

   a_ack_release: assert property (@(posedge core_clk) disable iff (!nrst) // RQ21
      s_ack |=> sc_status == 16'h0000 && !comm_alarm)
      else $error("acknowledge did not release link alarm");

   a_pause_dark: assert property (@(posedge core_clk) disable iff (!nrst) // RQ22
      ce && fl_pause |=> !power_alarm_red)
      else $error("power alarm lit during pause");

endmodule

// File: tb/dam_led_model.sv
// Indicator model: counts the pulses of each flash burst of one red element.
// Assumes a registered led level on core_clk.
`timescale 1ns/10ps
module dam_led_model (
   input  wire logic  core_clk,
   input  wire logic  nrst,
   input  wire logic  led,
   output logic [4:0] burst_cnt
);
   logic [4:0] run;
   logic [9:0] dark;
   logic       led_q;
   // A dark spell of 40 cycles closes a burst; shorter gaps split pulses.
   always_ff @(posedge core_clk) begin
      led_q <= led;
      if (!nrst) begin
         run <= 5'h0;
         dark <= 10'h0;
         burst_cnt <= 5'h0;
      end else if (led) begin
         run <= run + 5'(!led_q);
         dark <= 10'h0;
      end else begin
         dark <= dark + 10'h1;
         if (dark == 10'h28 && run != 5'h0) begin
            burst_cnt <= run;
            run <= 5'h0;
         end
      end
   end
endmodule

// File: tb/drive_alarm_manager_bench.sv
// Bench of the alarm manager: faults, code objects, clears, flash counts.
// Assumes dam_core, the indicator model and one 40 MHz clock.
`timescale 1ns/10ps
module drive_alarm_manager_bench;
   import dam_pkg::*;
   logic core_clk, nrst, ce, halt, pwr, lnk, dflt;
   logic [7:0] pins;
   logic [15:0] rdata;
   logic [4:0] pwr_cnt, lnk_cnt;
   dam_bus_req_t bus_req;
   dam_comm_fault_t cf;
   int err_total, tests_run, seed, i;
   logic [15:0] cc [7] = '{16'h821B, 16'h871A, 16'h8732, 16'hA001, 16'hA005, 16'h8213, 16'h821D};
   logic [15:0] ch [7] = '{16'h001B, 16'h001A, 16'h0032, 16'h0011, 16'h0023, 16'h0, 16'h0};
   logic [4:0] cl [7] = '{5'h2, 5'h1, 5'h1, 5'h0, 5'h0, 5'h0, 5'h0};
   dam_core #(.TICK_CYCLES(4)) u_dut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
      .bus_req(bus_req), .rdata(rdata), .drv_fault_pin(pins), .comm_fault(cf),
      .motor_halt(halt), .power_alarm_red(pwr), .link_fault_red(lnk), .drive_in_fault(dflt));
   dam_led_model u_pwr (.core_clk(core_clk), .nrst(nrst), .led(pwr), .burst_cnt(pwr_cnt));
   dam_led_model u_lnk (.core_clk(core_clk), .nrst(nrst), .led(lnk), .burst_cnt(lnk_cnt));
   // Clock of 25 ns period.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic report_and_stop();
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk) bus_req <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk) bus_req <= '0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge core_clk) bus_req <= '{1'b0, 1'b1, a, 16'h0};
      @(posedge core_clk) bus_req <= '0;
      #1 chk(rdata, exp);
   endtask
   // Waits, bounded, for the first whole burst on one indicator.
   task automatic wait_burst(input logic which);
      int n;
      n = 0;
      while ((which ? lnk_cnt : pwr_cnt) == 5'h0) begin
         @(posedge core_clk);
         #1;
         n++;
         if (n > 3000) begin
            err_total++;
            report_and_stop();
         end
      end
   endtask
   task automatic pcyc();
      @(posedge core_clk) nrst <= 1'b0;
      @(posedge core_clk) nrst <= 1'b1;
   endtask
   // Main sequence: each drive fault, two overlapping faults, link faults.
   initial begin
      seed = 32'h4e5d;
      err_total = 0;
      tests_run = 0;
      nrst = 1'b0;
      ce = 1'b1;
      pins = 8'h0;
      bus_req = '0;
      cf = '0;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      for (i = 0; i < NDRV; i++) begin
         pins <= 8'(1 << i);
         repeat (6) @(posedge core_clk);
         #1 chk({14'h0, halt, dflt}, 16'h3);
         rd(OBJ_HIST, DRV_HIST[i]);
         rd(OBJ_ERRREG, {8'h0, DRV_ERR[i]});
         rd(OBJ_ERRCODE, DRV_PROF[i]);
         wait_burst(1'b0);
         chk({11'h0, pwr_cnt}, {12'h0, DRV_FLASH[i]});
         @(posedge core_clk) pins <= 8'h0;
         repeat (4) @(posedge core_clk);
         wr(OBJ_ALMCLR, 16'($random(seed)) | 16'h0002);
         rd(OBJ_ERRCODE, DRV_PROF[i]);
         wr(OBJ_ALMCLR, CLR_VAL);
         rd(OBJ_ERRCODE, DRV_CLEARABLE[i] ? 16'h0 : DRV_PROF[i]);
         wr(OBJ_CTRLWORD, 16'h0);
         wr(OBJ_CTRLWORD, 16'h0080);
         rd(OBJ_HIST, DRV_HIST[i]);
         chk({15'h0, halt}, {15'h0, ~DRV_CLEARABLE[i]});
         if (DRV_CLEARABLE[i]) begin
            chk({15'h0, dflt}, 16'h0);
         end
         wr(OBJ_HISTCLR, CLR_VAL);
         rd(OBJ_HIST, 16'h0);
         pcyc();
      end
      pins <= 8'h40;
      repeat (6) @(posedge core_clk);
      pins <= 8'h50;
      repeat (6) @(posedge core_clk);
      rd(OBJ_ERRCODE, 16'h8402);
      rd(OBJ_HIST, DRV_HIST[4]);
      pins <= 8'h0;
      pcyc();
      for (i = 0; i < 7; i++) begin
         @(posedge core_clk) cf <= '{1'b1, cc[i]};
         @(posedge core_clk) cf <= '0;
         rd(OBJ_ERRREG, 16'h0010);
         rd(OBJ_ERRCODE, cc[i]);
         rd(OBJ_HIST, ch[i]);
         if (cl[i] != 5'h0) begin
            wait_burst(1'b1);
            chk({11'h0, lnk_cnt}, {11'h0, cl[i]});
         end
         wr(SC_CTRL, 16'h0010);
         repeat (2) @(posedge core_clk);
         rd(SC_STATUS, 16'h0);
         rd(OBJ_ERRREG, 16'h0);
         pcyc();
      end
      // Clock enable low must freeze the synchroniser and the latches.
      ce <= 1'b0;
      pins <= 8'h01;
      repeat (6) @(posedge core_clk);
      #1 chk({15'h0, halt}, 16'h0);
      @(posedge core_clk) ce <= 1'b1;
      repeat (6) @(posedge core_clk);
      #1 chk({15'h0, halt}, 16'h1);
      rd(OBJ_ERRCODE, DRV_PROF[0]);
      report_and_stop();
   end
endmodule
